// [include/sbsc_pkg.sv]
// Shared constants and types of the burst SRAM control block
package sbsc_pkg;
	localparam int LANES_DEF    = 4;
	localparam int LANE_BITS    = 9;
	localparam int PARITY_POS   = 8;
	localparam int ADDR_W_DEF   = 18;
	localparam int WQ_DEPTH_DEF = 32;
	localparam int BURST_BITS   = 2;

	localparam logic [1:0] BURST_START     = 2'h0;
	localparam logic [1:0] BURST_STEP      = 2'h1;
	localparam logic [1:0] SLEEP_CNT_RST   = 2'h0;
	localparam logic [1:0] SLEEP_ENTRY_CYC = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_DESEL = 4'h2,
		ST_READ  = 4'h4,
		ST_WRITE = 4'h8
	} sbsc_state_t;
endpackage

// [core/sbsc_fifo.sv]
// Write queue between the data pins and the memory core
`timescale 1ns/1ps
module sbsc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("sbsc_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic [AW:0]   count_next;
	logic          push;
	logic          pop;

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = (count_reg != '0) && (!out_valid_out || out_ready_in);
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_out <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_next;
			// Registered ready costs nothing: next count is known
			in_ready_out <= count_next < (AW+1)'(DEPTH);
		end
	end

	// Read data always leave through a register
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out <= mem[rd_ptr_reg];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule // sbsc_fifo

// [core/sbsc_ctrl.sv]
// Command decode, burst counter and data pipeline of the burst SRAM
`timescale 1ns/1ps
module sbsc_ctrl
	import sbsc_pkg::*;
#(
	parameter int LANES    = LANES_DEF,
	parameter int ADDR_W   = ADDR_W_DEF,
	parameter int WQ_DEPTH = WQ_DEPTH_DEF
) (
	input  wire logic                          CLK_IN,
	input  wire logic                          SRST_IN,
	input  wire logic                          CLK_GATE_N_IN,
	input  wire logic                          BURST_STEP_OR_LOAD_IN,
	input  wire logic                          STORE_SELECT_N_IN,
	input  wire logic [LANES-1:0]              BYTE_LANE_MASK_N_IN,
	input  wire logic                          CHIP_SELECT_FIRST_N_IN,
	input  wire logic                          CHIP_SELECT_SECOND_IN,
	input  wire logic                          CHIP_SELECT_THIRD_N_IN,
	input  wire logic                          OUTPUT_DRIVE_N_IN,
	input  wire logic                          SLEEP_REQUEST_IN,
	input  wire logic                          FLOW_THROUGH_SELECT_N_IN,
	input  wire logic                          BURST_ORDER_SELECT_N_IN,
	input  wire logic                          DRIVE_STRENGTH_SELECT_IN,
	input  wire logic                          PARITY_LANE_CONTROL_N_IN,
	input  wire logic [ADDR_W-1:0]             ADDR_IN,
	input  wire logic [LANES*LANE_BITS-1:0]    DQ_IN,
	output logic      [LANES*LANE_BITS-1:0]    DQ_OUT,
	output logic                               DQ_OE_OUT,
	output logic                               DRIVE_HIGH_OUT,
	output logic                               SLEEP_ACTIVE_OUT,
	output logic                               CORE_RD_EN_OUT,
	output logic      [ADDR_W-1:0]             CORE_RD_ADDR_OUT,
	input  wire logic [LANES*LANE_BITS-1:0]    CORE_RDATA_IN,
	output logic                               CORE_WR_VALID_OUT,
	output logic      [ADDR_W-1:0]             CORE_WR_ADDR_OUT,
	output logic      [LANES*LANE_BITS-1:0]    CORE_WR_DATA_OUT,
	output logic      [LANES-1:0]              CORE_WR_MASK_N_OUT,
	input  wire logic                          CORE_WR_READY_IN,
	output logic                               WQ_READY_OUT
);
	localparam int DW   = LANES * LANE_BITS;
	localparam int WQ_W = ADDR_W + DW + LANES;

	if (LANES < 1 || ADDR_W <= BURST_BITS) begin : g_bad_size
		$error("sbsc_ctrl: LANES and ADDR_W too small");
	end

	function automatic logic [1:0] burst_low(input logic [1:0] base,
		input logic [1:0] step, input logic ilv);
		burst_low = ilv ? (base ^ step) : 2'(base + step);
	endfunction

	function automatic logic [DW-1:0] lane_fix(input logic [DW-1:0] d,
		input logic pe_n);
		lane_fix = d;
		for (int i = 0; i < LANES; i++) begin
			if (pe_n) begin
				lane_fix[i*LANE_BITS+PARITY_POS] = 1'b0;
			end
		end
	endfunction

	sbsc_state_t         st_reg;
	sbsc_state_t         st_next;
	logic                en;
	logic                sel;
	logic                any_byte;
	logic                ft;
	logic                ilv;
	logic                do_load;
	logic                do_step;
	logic                acc_rd;
	logic                acc_wr;
	logic [1:0]          base_reg;
	logic [1:0]          bcnt_reg;
	logic [1:0]          bcnt_next;
	logic [1:0]          step_low;
	logic [ADDR_W-1:0]   acc_addr;
	logic [ADDR_W-BURST_BITS-1:0] upper_reg;
	logic                s1_rd_reg;
	logic                s1_wr_reg;
	logic [ADDR_W-1:0]   s1_addr_reg;
	logic [LANES-1:0]    s1_mask_reg;
	logic                s2_rd_reg;
	logic                s2_wr_reg;
	logic [ADDR_W-1:0]   s2_addr_reg;
	logic [LANES-1:0]    s2_mask_reg;
	logic [DW-1:0]       s2_data_reg;
	logic                rd_slot;
	logic [DW-1:0]       rd_data;
	logic                wr_slot;
	logic [ADDR_W-1:0]   wr_addr;
	logic [LANES-1:0]    wr_mask;
	logic                drive_reg;
	logic [1:0]          zz_cnt_reg;
	logic [1:0]          zz_cnt_next;
	logic                sleep_reg;
	logic                sleep_next;
	logic                wq_push;
	logic [WQ_W-1:0]     wq_push_data;
	logic [WQ_W-1:0]     wq_out_data;

	// Pin decode; inactive levels of the mode pins give the default modes
	always_comb begin
		en = !CLK_GATE_N_IN && !sleep_reg;
		sel = !CHIP_SELECT_FIRST_N_IN && CHIP_SELECT_SECOND_IN && !CHIP_SELECT_THIRD_N_IN;
		any_byte = !(&BYTE_LANE_MASK_N_IN);
		ft = !FLOW_THROUGH_SELECT_N_IN;
		ilv = BURST_ORDER_SELECT_N_IN;
	end

	// Command decode for one enabled edge
	always_comb begin
		st_next = st_reg;
		do_load = 1'b0;
		do_step = 1'b0;
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		if (!BURST_STEP_OR_LOAD_IN) begin
			if (!sel) begin
				st_next = ST_DESEL;
			end else if (STORE_SELECT_N_IN) begin
				st_next = ST_READ;
				do_load = 1'b1;
				acc_rd = 1'b1;
			end else if (any_byte) begin
				st_next = ST_WRITE;
				do_load = 1'b1;
				acc_wr = 1'b1;
			end else begin
				st_next = ST_DESEL;
			end
		end else begin
			case (st_reg)
				ST_READ: begin
					do_step = 1'b1;
					acc_rd = 1'b1;
				end
				ST_WRITE: begin
					do_step = 1'b1;
					acc_wr = any_byte;
				end
				ST_DESEL: begin
					st_next = ST_DESEL;
				end
				ST_IDLE: begin
					st_next = ST_IDLE;
				end
				default: begin
					st_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			st_reg <= ST_IDLE;
		end else if (en) begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		bcnt_next = 2'(bcnt_reg + BURST_STEP);
		step_low = burst_low(base_reg, bcnt_next, ilv);
		acc_addr = do_load ? ADDR_IN : {upper_reg, step_low};
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			base_reg <= BURST_START;
			bcnt_reg <= BURST_START;
			upper_reg <= '0;
		end else if (en && do_load) begin
			base_reg <= ADDR_IN[BURST_BITS-1:0];
			bcnt_reg <= BURST_START;
			upper_reg <= ADDR_IN[ADDR_W-1:BURST_BITS];
		end else if (en && do_step) begin
			bcnt_reg <= bcnt_next;
		end
	end

	// Access stage: the core sees the address one edge after the command
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			s1_rd_reg <= 1'b0;
			s1_wr_reg <= 1'b0;
			s1_addr_reg <= '0;
			s1_mask_reg <= '1;
		end else if (en) begin
			s1_rd_reg <= acc_rd;
			s1_wr_reg <= acc_wr;
			s1_addr_reg <= acc_addr;
			s1_mask_reg <= BYTE_LANE_MASK_N_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			s2_rd_reg <= 1'b0;
			s2_wr_reg <= 1'b0;
			s2_addr_reg <= '0;
			s2_mask_reg <= '1;
			s2_data_reg <= '0;
		end else if (en) begin
			s2_rd_reg <= s1_rd_reg;
			s2_wr_reg <= s1_wr_reg;
			s2_addr_reg <= s1_addr_reg;
			s2_mask_reg <= s1_mask_reg;
			s2_data_reg <= CORE_RDATA_IN;
		end
	end

	always_comb begin
		rd_slot = ft ? s1_rd_reg : s2_rd_reg;
		rd_data = ft ? CORE_RDATA_IN : s2_data_reg;
		wr_slot = ft ? s1_wr_reg : s2_wr_reg;
		wr_addr = ft ? s1_addr_reg : s2_addr_reg;
		wr_mask = ft ? s1_mask_reg : s2_mask_reg;
		wq_push = en && wr_slot;
		wq_push_data = {wr_addr, lane_fix(DQ_IN, PARITY_LANE_CONTROL_N_IN), wr_mask};
	end

	always_comb begin
		if (!SLEEP_REQUEST_IN) begin
			zz_cnt_next = SLEEP_CNT_RST;
		end else if (zz_cnt_reg == SLEEP_ENTRY_CYC) begin
			zz_cnt_next = zz_cnt_reg;
		end else begin
			zz_cnt_next = 2'(zz_cnt_reg + BURST_STEP);
		end
		sleep_next = zz_cnt_next == SLEEP_ENTRY_CYC;
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			zz_cnt_reg <= SLEEP_CNT_RST;
			sleep_reg <= 1'b0;
		end else begin
			zz_cnt_reg <= zz_cnt_next;
			sleep_reg <= sleep_next;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			drive_reg <= 1'b0;
		end else if (en) begin
			drive_reg <= rd_slot;
		end
	end

	// Drive control is sampled, so it acts one edge late
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			DQ_OE_OUT <= 1'b0;
			DQ_OUT <= '0;
		end else begin
			DQ_OE_OUT <= (en ? rd_slot : drive_reg) && !OUTPUT_DRIVE_N_IN && !sleep_next;
			if (en && rd_slot) begin
				DQ_OUT <= lane_fix(rd_data, PARITY_LANE_CONTROL_N_IN);
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			DRIVE_HIGH_OUT <= 1'b0;
		end else begin
			DRIVE_HIGH_OUT <= !DRIVE_STRENGTH_SELECT_IN;
		end
	end

	always_comb begin
		SLEEP_ACTIVE_OUT = sleep_reg;
		CORE_RD_EN_OUT = s1_rd_reg;
		CORE_RD_ADDR_OUT = s1_addr_reg;
		CORE_WR_ADDR_OUT = wq_out_data[WQ_W-1 -: ADDR_W];
		CORE_WR_DATA_OUT = wq_out_data[LANES +: DW];
		CORE_WR_MASK_N_OUT = wq_out_data[LANES-1:0];
	end

	// A write taken while the queue is full is lost
	sbsc_fifo #(
		.W     (WQ_W),
		.DEPTH (WQ_DEPTH)
	) u_wq (
		.clk_in        (CLK_IN),
		.srst_in       (SRST_IN),
		.in_valid_in   (wq_push),
		.in_data_in    (wq_push_data),
		.in_ready_out  (WQ_READY_OUT),
		.out_valid_out (CORE_WR_VALID_OUT),
		.out_data_out  (wq_out_data),
		.out_ready_in  (CORE_WR_READY_IN)
	);

	logic [1:0] lin_low;
	logic [1:0] ilv_low;
	logic       burst_go;

	always_comb begin
		lin_low = burst_low(base_reg, bcnt_next, 1'b0);
		ilv_low = burst_low(base_reg, bcnt_next, 1'b1);
		burst_go = en && BURST_STEP_OR_LOAD_IN && (st_reg == ST_READ || st_reg == ST_WRITE);
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);

	ft_read_lat_a: assert property (
		en && ft && acc_rd && !OUTPUT_DRIVE_N_IN && !SLEEP_REQUEST_IN
		##1 en && !OUTPUT_DRIVE_N_IN && !SLEEP_REQUEST_IN |=> DQ_OE_OUT)
		else $error("flow-through read not driven one edge after command");

	pipe_read_lat_a: assert property (
		en && !ft && acc_rd ##1 en && !OUTPUT_DRIVE_N_IN && !SLEEP_REQUEST_IN
		|=> !DQ_OE_OUT || $past(s2_rd_reg))
		else $error("pipeline read driven too early");

	ft_wr_cap_a: assert property (
		en && ft && acc_wr ##1 en |-> wq_push)
		else $error("flow-through write data not taken at second edge");

	pipe_wr_cap_a: assert property (
		en && !ft && acc_wr ##1 en ##1 en |-> wq_push)
		else $error("pipeline write data not taken two edges later");

	abort_nop_a: assert property (
		en && !BURST_STEP_OR_LOAD_IN && sel && !STORE_SELECT_N_IN && !any_byte
		|=> !s1_wr_reg && !s1_rd_reg)
		else $error("write abort performed an access");

	desel_idle_a: assert property (
		en && !BURST_STEP_OR_LOAD_IN && !sel |=> !s1_rd_reg && !s1_wr_reg ##1 !wq_push)
		else $error("deselect performed an access");

	stall_hold_a: assert property (
		CLK_GATE_N_IN && !sleep_reg |=> $stable(bcnt_reg) && $stable(s1_addr_reg)
		&& $stable(st_reg))
		else $error("state changed on a gated edge");

	write_hiz_a: assert property (
		en && wr_slot && !sleep_reg |=> !DQ_OE_OUT)
		else $error("data driven during a write slot");

	burst_count_a: assert property (
		burst_go |=> bcnt_reg == 2'($past(bcnt_reg) + BURST_STEP))
		else $error("burst counter did not advance");

	linear_order_a: assert property (
		burst_go && !ilv |=> s1_addr_reg[1:0] == $past(lin_low))
		else $error("linear burst address wrong");

	ilv_order_a: assert property (
		burst_go && ilv |=> s1_addr_reg[1:0] == $past(ilv_low))
		else $error("interleaved burst address wrong");

	sleep_entry_a: assert property (
		SLEEP_REQUEST_IN ##1 SLEEP_REQUEST_IN |=> SLEEP_ACTIVE_OUT && !DQ_OE_OUT)
		else $error("sleep not entered after two cycles");

	reset_hiz_a: assert property (
		$fell(SRST_IN) |-> !DQ_OE_OUT)
		else $error("data driven right after reset");
endmodule // sbsc_ctrl

// [tb/sbsc_core_model.sv]
// Behavioural memory core behind the burst SRAM control block
`timescale 1ns/1ps
module sbsc_core_model (
	input  wire logic        clk_in,
	input  wire logic        stall_in,
	input  wire logic        rd_en_in,
	input  wire logic [17:0] rd_addr_in,
	output logic      [35:0] rdata_out,
	input  wire logic        wr_valid_in,
	input  wire logic [17:0] wr_addr_in,
	input  wire logic [35:0] wr_data_in,
	input  wire logic [3:0]  wr_mask_n_in,
	output logic             wr_ready_out
);
	logic [35:0] mem [256];
	logic [35:0] last_reg;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {4{1'b1, 8'(i)}};
		end
		last_reg = '0;
	end
	// Idle bus shows inverted last word so stale data cannot pass
	assign rdata_out = rd_en_in ? mem[rd_addr_in[7:0]] : ~last_reg;
	assign wr_ready_out = !stall_in;
	always @(posedge clk_in) begin
		if (rd_en_in) begin
			last_reg <= mem[rd_addr_in[7:0]];
		end
		if (wr_valid_in && wr_ready_out) begin
			for (int l = 0; l < 4; l++) begin
				if (!wr_mask_n_in[l]) begin
					mem[wr_addr_in[7:0]][9*l +: 9] <= wr_data_in[9*l +: 9];
				end
			end
		end
	end
endmodule // sbsc_core_model

// [tb/sync_burst_sram_control_test.sv]
// Self-checking bench of the burst SRAM control block
`timescale 1ns/1ps
module sync_burst_sram_control_test;
	import sbsc_pkg::*;
	localparam logic [2:0]  ON = 3'b010;
	localparam logic [2:0]  OFF = 3'b110;
	localparam logic [35:0] LM = 36'h007FC01FF;
	localparam logic [35:0] WD = 36'h987654321;
	logic        clk = 0, srst = 1, gate_n = 0, step = 0, we_n = 1, oe_n = 0, sleep = 0;
	logic        ft_n = 1, ilv = 0, ds = 1, pe_n = 0, stall = 0, full = 0;
	logic [2:0]  sel = OFF;
	logic [3:0]  mask_n = 4'hF;
	logic [17:0] addr = '0, wa;
	logic [35:0] dq_in = '0;
	logic [35:0] dq_out, rdata, wr_data;
	logic [17:0] rd_addr, wr_addr;
	logic [3:0]  wr_mask_n;
	logic        dq_oe, drive_high, sleep_act, rd_en, wr_valid, wr_ready, wq_ready;
	logic [36:0] cap [$];
	int          err_total = 0, check_count = 0, cycles = 0;
	logic [2:0]  desel [3] = '{3'b110, 3'b000, 3'b011};
	// Rows: flow-through n, interleave, parity n, start pair, five expected pairs
	logic [14:0] rows [4] = '{
		{3'b100, 2'h1, 10'b01_10_11_00_01},
		{3'b110, 2'h2, 10'b10_11_00_01_10},
		{3'b001, 2'h3, 10'b11_00_01_10_11},
		{3'b010, 2'h1, 10'b01_00_11_10_01}
	};

	always #5 clk = ~clk;

	sbsc_ctrl dut_u (
		.CLK_IN(clk), .SRST_IN(srst), .CLK_GATE_N_IN(gate_n), .BURST_STEP_OR_LOAD_IN(step),
		.STORE_SELECT_N_IN(we_n), .BYTE_LANE_MASK_N_IN(mask_n),
		.CHIP_SELECT_FIRST_N_IN(sel[2]), .CHIP_SELECT_SECOND_IN(sel[1]),
		.CHIP_SELECT_THIRD_N_IN(sel[0]), .OUTPUT_DRIVE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep),
		.FLOW_THROUGH_SELECT_N_IN(ft_n), .BURST_ORDER_SELECT_N_IN(ilv),
		.DRIVE_STRENGTH_SELECT_IN(ds), .PARITY_LANE_CONTROL_N_IN(pe_n), .ADDR_IN(addr),
		.DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe), .DRIVE_HIGH_OUT(drive_high),
		.SLEEP_ACTIVE_OUT(sleep_act), .CORE_RD_EN_OUT(rd_en), .CORE_RD_ADDR_OUT(rd_addr),
		.CORE_RDATA_IN(rdata), .CORE_WR_VALID_OUT(wr_valid), .CORE_WR_ADDR_OUT(wr_addr),
		.CORE_WR_DATA_OUT(wr_data), .CORE_WR_MASK_N_OUT(wr_mask_n),
		.CORE_WR_READY_IN(wr_ready), .WQ_READY_OUT(wq_ready)
	);

	sbsc_core_model core_u (
		.clk_in(clk), .stall_in(stall), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
		.rdata_out(rdata), .wr_valid_in(wr_valid), .wr_addr_in(wr_addr),
		.wr_data_in(wr_data), .wr_mask_n_in(wr_mask_n), .wr_ready_out(wr_ready)
	);

	function automatic logic [35:0] pat(input logic [17:0] a, input logic p);
		return {4{!p, a[7:0]}};
	endfunction

	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic burst_step_or_load, input logic wn, input logic [3:0] m,
			input logic [2:0] s, input logic [17:0] a, input logic [35:0] d);
		step = burst_step_or_load;
		we_n = wn;
		mask_n = m;
		sel = s;
		addr = a;
		dq_in = d;
		@(posedge clk);
		#1;
		cap.push_back({dq_oe, dq_out});
	endtask

	task automatic rst();
		srst = 1;
		repeat (2) @(posedge clk);
		#1;
		srst = 0;
		cap.delete();
	endtask

	task automatic drain();
		for (int i = 0; i < 300 && wr_valid !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Ceiling far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		#1;
		srst = 0;
		chk({dq_oe, wq_ready, wr_valid, sleep_act, drive_high}, 37'b01000);
		repeat (3) cmd(1, 1, 4'hF, ON, 18'h5, '0);
		cmd(0, 1, 4'hF, ON, 18'h5, '0);
		foreach (desel[i]) cmd(0, 1, 4'hF, desel[i], 18'h5, '0);
		repeat (2) cmd(1, 1, 4'hF, ON, 18'h5, '0);
		for (int i = 0; i < 9; i++) chk(cap[i][36], i == 5);
		// mode pins static
		// Mode pins move only just before reset is raised
		foreach (rows[r]) begin
			{ft_n, ilv, pe_n} = rows[r][14:12];
			rst();
			cmd(0, 1, 4'hF, ON, {16'h4, rows[r][11:10]}, '0);
			repeat (4) cmd(1, 1, 4'hF, 3'b000, '0, '0);
			repeat (2) cmd(0, 1, 4'hF, OFF, '0, '0);
			for (int i = 0; i < 5; i++)
				chk(cap[i+1+ft_n], {1'b1, pat({16'h4, rows[r][9-2*i -: 2]}, pe_n)});
		end
		for (int k = 0; k < 2; k++) begin
			ft_n = !k[0];
			ilv = 0;
			pe_n = 0;
			wa = 18'h30 + 18'(2 * k);
			rst();
			cmd(0, 1, 4'hF, ON, 18'h20, '0);
			cmd(0, 0, 4'hA, ON, wa, '0);
			cmd(0, 0, 4'hF, ON, wa + 18'h1, ft_n ? 36'h0 : WD);
			cmd(0, 1, 4'hF, OFF, '0, ft_n ? WD : 36'h0);
			cmd(0, 1, 4'hF, OFF, '0, '0);
			chk(cap[1+ft_n], {1'b1, pat(18'h20, 1'b0)});
			chk(cap[2+ft_n][36], 1'b0);
			chk(cap[3+ft_n][36], 1'b0);
			drain();
			cap.delete();
			cmd(0, 1, 4'hF, ON, wa, '0);
			cmd(0, 1, 4'hF, ON, wa + 18'h1, '0);
			repeat (2) cmd(0, 1, 4'hF, OFF, '0, '0);
			chk(cap[1+ft_n], {1'b1, (WD & LM) | (pat(wa, 1'b0) & ~LM)});
			chk(cap[2+ft_n], {1'b1, pat(wa + 18'h1, 1'b0)});
		end
		ft_n = 1;
		rst();
		cmd(0, 1, 4'hF, ON, 18'h21, '0);
		repeat (2) cmd(0, 1, 4'hF, OFF, '0, '0);
		gate_n = 1;
		repeat (3) cmd(0, 1, 4'hF, OFF, '0, '0);
		gate_n = 0;
		cmd(0, 1, 4'hF, OFF, '0, '0);
		for (int i = 2; i < 6; i++) chk(cap[i], {1'b1, pat(18'h21, 1'b0)});
		chk(cap[6][36], 1'b0);
		oe_n = 1;
		cap.delete();
		cmd(0, 1, 4'hF, OFF, '0, '0);
		cmd(0, 1, 4'hF, ON, 18'h22, '0);
		repeat (2) cmd(0, 1, 4'hF, OFF, '0, '0);
		chk(cap[3][36], 1'b0);
		oe_n = 0;
		sleep = 1;
		cmd(0, 1, 4'hF, OFF, '0, '0);
		chk(sleep_act, 1'b0);
		cmd(0, 1, 4'hF, OFF, '0, '0);
		chk({sleep_act, dq_oe}, 2'b10);
		sleep = 0;
		cmd(0, 1, 4'hF, OFF, '0, '0);
		chk(sleep_act, 1'b0);
		ds = 0;
		rst();
		// Drive output is registered: one edge out of reset first
		cmd(0, 1, 4'hF, OFF, '0, '0);
		chk(drive_high, 1'b1);
		stall = 1;
		cmd(0, 0, 4'h0, ON, 18'h40, 36'h5);
		for (int i = 0; i < 40; i++) begin
			cmd(1, 0, 4'h0, 3'b000, '0, 36'h5);
			if (wq_ready === 1'b0) full = 1;
		end
		chk(full, 1'b1);
		stall = 0;
		repeat (2) cmd(0, 1, 4'hF, OFF, '0, '0);
		drain();
		chk({wr_valid, wq_ready}, 2'b01);
		report_and_stop();
	end
endmodule // sync_burst_sram_control_test
